// file: include/sfrc_pkg.sv
// synthesizer carrier word, reference clock output and start-up sequencer constants
// assumes a single system clock that is the reference oscillator itself
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
package sfrc_pkg;
   // register addresses, 7-bit serial port address space
   localparam logic [6:0] ADDR_OP_MODE = 7'h01;
   localparam logic [6:0] ADDR_FREQ_HIGH = 7'h07;
   localparam logic [6:0] ADDR_FREQ_MID = 7'h08;
   localparam logic [6:0] ADDR_FREQ_LOW = 7'h09;
   localparam logic [6:0] ADDR_PIN_MAP_SECOND = 7'h26;
   localparam logic [6:0] ADDR_SEQ_STATUS = 7'h27;
   localparam logic [6:0] ADDR_EXT_REF_SEL = 7'h59;
   // reset values
   localparam logic [7:0] RST_OP_MODE = 8'h04;
   localparam logic [7:0] RST_FREQ_BYTE = 8'h00;
   localparam logic [7:0] RST_PIN_MAP_SECOND = 8'h00;
   localparam logic [7:0] RST_EXT_REF_SEL = 8'h00;
   // field positions
   localparam int OP_SEQ_OFF_BIT = 7;
   localparam int OP_MODE_LSB = 2;
   localparam int OP_MODE_W = 3;
   localparam int PM_DIV_SEL_LSB = 0;
   localparam int PM_DIV_SEL_W = 3;
   localparam int PM_PIN4_LOCK_BIT = 6;
   localparam int EXT_REF_BIT = 4;
   localparam int SIGMA_DELTA_BITS = 19;
   localparam int FREQ_WORD_W = 24;
   // operating mode codes
   localparam logic [2:0] MODE_SLEEP = 3'h0;
   localparam logic [2:0] MODE_STANDBY = 3'h1;
   localparam logic [2:0] MODE_SYNTH = 3'h2;
   localparam logic [2:0] MODE_TX = 3'h3;
   localparam logic [2:0] MODE_RX = 3'h4;
   // divider select codes at and above this one switch the clock output off
   localparam logic [2:0] DIV_SEL_OFF = 3'h6;
   localparam int DIV_CNT_W = 6;
   localparam int SPI_BYTE_W = 8;

   typedef enum logic [2:0] {
      SEQ_SLEEP,
      SEQ_OSC_WAIT,
      SEQ_STANDBY,
      SEQ_PLL_WAIT,
      SEQ_SYNTH,
      SEQ_TX,
      SEQ_RX
   } sfrc_seq_t;

   // one register write, a one-cycle strobe with its address and data
   typedef struct packed {
      logic en;
      logic [6:0] addr;
      logic [7:0] data;
   } sfrc_reg_wr_t;
endpackage

// file: hw/sfrc_spi_slave.sv
// serial register port slave: chip select framed, mode 0, msb first
// assumes sck, mosi and nss come from pins and are slow against sys_clk_in
`timescale 1ns/1ps
module sfrc_spi_slave (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic spi_sck_in,
   input wire logic spi_mosi_in,
   input wire logic spi_nss_n_in,
   input wire logic [7:0] rd_data_in,
   output logic [6:0] rd_addr_out,
   output sfrc_pkg::sfrc_reg_wr_t wr_out,
   output logic spi_miso_out,
   output logic spi_miso_oe_out
);
   // -----------------------------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------------------------
   logic [1:0] sck_meta_reg, mosi_meta_reg, nss_meta_reg;
   logic sck_reg, mosi_reg, nss_n_reg, sck_prev_reg;
   logic [2:0] bit_cnt_reg;
   logic [7:0] shift_in_reg, shift_out_reg;
   logic addr_done_reg, is_write_reg, load_pend_reg;

   // first stage feeds only the second stage
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         sck_meta_reg <= 2'h0;
         mosi_meta_reg <= 2'h0;
         nss_meta_reg <= 2'h3;
      end else begin
         sck_meta_reg <= {sck_meta_reg[0], spi_sck_in};
         mosi_meta_reg <= {mosi_meta_reg[0], spi_mosi_in};
         nss_meta_reg <= {nss_meta_reg[0], spi_nss_n_in};
      end
   end

   assign sck_reg = sck_meta_reg[1];
   assign mosi_reg = mosi_meta_reg[1];
   assign nss_n_reg = nss_meta_reg[1];

   logic sck_rise, sck_fall;
   assign sck_rise = sck_reg & ~sck_prev_reg & ~nss_n_reg;
   assign sck_fall = ~sck_reg & sck_prev_reg & ~nss_n_reg;

   // -----------------------------------------------------------------------------
   // framing: address byte, then data bytes with auto-increment
   // -----------------------------------------------------------------------------
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         sck_prev_reg <= 1'b0;
         bit_cnt_reg <= 3'h0;
         shift_in_reg <= 8'h00;
         addr_done_reg <= 1'b0;
         is_write_reg <= 1'b0;
         rd_addr_out <= 7'h00;
         wr_out <= '0;
         load_pend_reg <= 1'b0;
      end else begin
         sck_prev_reg <= sck_reg;
         wr_out.en <= 1'b0;
         load_pend_reg <= 1'b0;
         if (nss_n_reg) begin
            bit_cnt_reg <= 3'h0;
            addr_done_reg <= 1'b0;
         end else if (sck_rise) begin
            shift_in_reg <= {shift_in_reg[6:0], mosi_reg};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
               if (!addr_done_reg) begin
                  addr_done_reg <= 1'b1;
                  is_write_reg <= shift_in_reg[6];
                  rd_addr_out <= {shift_in_reg[5:0], mosi_reg};
                  load_pend_reg <= ~shift_in_reg[6];
               end else begin
                  // a byte ends: write it on a write access, then step to the next address
                  wr_out.en <= is_write_reg;
                  wr_out.addr <= rd_addr_out;
                  wr_out.data <= {shift_in_reg[6:0], mosi_reg};
                  rd_addr_out <= rd_addr_out + 7'h01;
                  load_pend_reg <= ~is_write_reg;
               end
            end
         end
      end
   end

   // -----------------------------------------------------------------------------
   // read data out, changes on falling sck so it is stable at the rising edge
   // -----------------------------------------------------------------------------
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         shift_out_reg <= 8'h00;
         spi_miso_out <= 1'b0;
         spi_miso_oe_out <= 1'b0;
      end else begin
         spi_miso_oe_out <= ~nss_n_reg; // drive only while selected
         if (load_pend_reg) begin
            shift_out_reg <= {rd_data_in[6:0], 1'b0};
            spi_miso_out <= rd_data_in[7];
         end else if (sck_fall && addr_done_reg && bit_cnt_reg != 3'h0) begin
            shift_out_reg <= {shift_out_reg[6:0], 1'b0};
            spi_miso_out <= shift_out_reg[7];
         end
      end
   end
endmodule // sfrc_spi_slave

// file: hw/sfrc_top.sv
// carrier word registers, reference clock output and start-up sequencer
// assumes sys_clk_in is the reference oscillator; analog status arrives asynchronously
`timescale 1ns/1ps
module sfrc_top #(
   parameter int DIV_W = sfrc_pkg::DIV_CNT_W
) (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic spi_sck_in,
   input wire logic spi_mosi_in,
   input wire logic spi_nss_n_in,
   input wire logic osc_stable_in,
   input wire logic pll_lock_in,
   output logic spi_miso_out,
   output logic spi_miso_oe_out,
   output logic [23:0] synth_freq_word_out,
   output logic synth_freq_load_out,
   output logic osc_enable_out,
   output logic pll_enable_out,
   output logic tx_enable_out,
   output logic rx_enable_out,
   output logic coarse_cal_start_out,
   output logic fine_cal_start_out,
   output logic lock_indicate_out,
   output logic mapped_io_pin_four_out,
   output logic mapped_io_pin_five_out,
   output logic ext_ref_select_out
);
   // -----------------------------------------------------------------------------
   // elaboration checks
   // -----------------------------------------------------------------------------
   if (DIV_W < sfrc_pkg::DIV_CNT_W) begin : g_bad_div
      $error("DIV_W too small for the divider select range");
   end

   // -----------------------------------------------------------------------------
   // serial register port
   // -----------------------------------------------------------------------------
   sfrc_pkg::sfrc_reg_wr_t wr;
   logic [6:0] rd_addr;
   logic [7:0] rd_data;

   sfrc_spi_slave u_spi (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .spi_sck_in(spi_sck_in),
      .spi_mosi_in(spi_mosi_in),
      .spi_nss_n_in(spi_nss_n_in),
      .rd_data_in(rd_data),
      .rd_addr_out(rd_addr),
      .wr_out(wr),
      .spi_miso_out(spi_miso_out),
      .spi_miso_oe_out(spi_miso_oe_out)
   );

   // -----------------------------------------------------------------------------
   // analog status synchronisers
   // -----------------------------------------------------------------------------
   logic [1:0] osc_sync_reg, lock_sync_reg;
   logic osc_ok, lock_ok;

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         osc_sync_reg <= 2'h0;
         lock_sync_reg <= 2'h0;
      end else begin
         osc_sync_reg <= {osc_sync_reg[0], osc_stable_in};
         lock_sync_reg <= {lock_sync_reg[0], pll_lock_in};
      end
   end

   assign osc_ok = osc_sync_reg[1];
   assign lock_ok = lock_sync_reg[1];

   // -----------------------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------------------
   logic [7:0] op_mode_reg, freq_high_reg, freq_mid_reg, freq_low_reg;
   logic [7:0] pin_map_reg, ext_ref_reg;
   logic [2:0] mode_sel;
   logic [2:0] div_sel;
   logic seq_manual;

   assign mode_sel = op_mode_reg[sfrc_pkg::OP_MODE_LSB +: sfrc_pkg::OP_MODE_W];
   assign seq_manual = op_mode_reg[sfrc_pkg::OP_SEQ_OFF_BIT];
   assign div_sel = pin_map_reg[sfrc_pkg::PM_DIV_SEL_LSB +: sfrc_pkg::PM_DIV_SEL_W];

   // host writes land here one cycle after the byte completes on the port
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         op_mode_reg <= sfrc_pkg::RST_OP_MODE;
         freq_high_reg <= sfrc_pkg::RST_FREQ_BYTE;
         freq_mid_reg <= sfrc_pkg::RST_FREQ_BYTE;
         freq_low_reg <= sfrc_pkg::RST_FREQ_BYTE;
         pin_map_reg <= sfrc_pkg::RST_PIN_MAP_SECOND;
         ext_ref_reg <= sfrc_pkg::RST_EXT_REF_SEL;
      end else if (wr.en) begin
         if (wr.addr == sfrc_pkg::ADDR_OP_MODE) begin
            op_mode_reg <= wr.data;
         end else if (wr.addr == sfrc_pkg::ADDR_FREQ_HIGH) begin
            freq_high_reg <= wr.data;
         end else if (wr.addr == sfrc_pkg::ADDR_FREQ_MID) begin
            freq_mid_reg <= wr.data;
         end else if (wr.addr == sfrc_pkg::ADDR_FREQ_LOW) begin
            freq_low_reg <= wr.data;
         end else if (wr.addr == sfrc_pkg::ADDR_PIN_MAP_SECOND) begin
            pin_map_reg <= wr.data;
         end else if (wr.addr == sfrc_pkg::ADDR_EXT_REF_SEL) begin
            ext_ref_reg <= wr.data;
         end
      end
   end

   // read mux, settled long before the port shifts the byte out
   always_comb begin
      rd_data = 8'h00;
      if (rd_addr == sfrc_pkg::ADDR_OP_MODE) begin
         rd_data = op_mode_reg;
      end else if (rd_addr == sfrc_pkg::ADDR_FREQ_HIGH) begin
         rd_data = freq_high_reg;
      end else if (rd_addr == sfrc_pkg::ADDR_FREQ_MID) begin
         rd_data = freq_mid_reg;
      end else if (rd_addr == sfrc_pkg::ADDR_FREQ_LOW) begin
         rd_data = freq_low_reg;
      end else if (rd_addr == sfrc_pkg::ADDR_PIN_MAP_SECOND) begin
         rd_data = pin_map_reg;
      end else if (rd_addr == sfrc_pkg::ADDR_SEQ_STATUS) begin
         rd_data = {6'h00, lock_ok, osc_ok};
      end else if (rd_addr == sfrc_pkg::ADDR_EXT_REF_SEL) begin
         rd_data = ext_ref_reg;
      end
   end

   // -----------------------------------------------------------------------------
   // carrier word
   // -----------------------------------------------------------------------------
   // the word moves as one on the low byte, so the synthesizer never sees
   // a half-updated frequency between the three byte writes
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         synth_freq_word_out <= {3{sfrc_pkg::RST_FREQ_BYTE}};
         synth_freq_load_out <= 1'b0;
      end else begin
         synth_freq_load_out <= 1'b0;
         if (wr.en && wr.addr == sfrc_pkg::ADDR_FREQ_LOW) begin
            synth_freq_word_out <= {freq_high_reg, freq_mid_reg, wr.data};
            synth_freq_load_out <= 1'b1;
         end
      end
   end

   // -----------------------------------------------------------------------------
   // start-up sequencer
   // -----------------------------------------------------------------------------
   // target state for a mode code; unused codes park in standby
   function automatic sfrc_pkg::sfrc_seq_t mode_state(input logic [2:0] mode);
      case (mode)
         sfrc_pkg::MODE_SLEEP: mode_state = sfrc_pkg::SEQ_SLEEP;
         sfrc_pkg::MODE_SYNTH: mode_state = sfrc_pkg::SEQ_SYNTH;
         sfrc_pkg::MODE_TX: mode_state = sfrc_pkg::SEQ_TX;
         sfrc_pkg::MODE_RX: mode_state = sfrc_pkg::SEQ_RX;
         default: mode_state = sfrc_pkg::SEQ_STANDBY;
      endcase
   endfunction

   // states in which the pll must run
   function automatic logic needs_pll(input sfrc_pkg::sfrc_seq_t st);
      needs_pll = (st == sfrc_pkg::SEQ_PLL_WAIT) || (st == sfrc_pkg::SEQ_SYNTH) ||
         (st == sfrc_pkg::SEQ_TX) || (st == sfrc_pkg::SEQ_RX);
   endfunction

   sfrc_pkg::sfrc_seq_t seq_reg, seq_next, mode_target;
   assign mode_target = mode_state(mode_sel);

   // waits on the ready signals rather than a worst-case delay
   always_comb begin
      seq_next = seq_reg;
      if (seq_manual) begin
         // manual: the host steps the modes and watches the status bits
         seq_next = mode_target;
      end else begin
         case (seq_reg)
            sfrc_pkg::SEQ_SLEEP: begin
               if (mode_target != sfrc_pkg::SEQ_SLEEP) begin
                  seq_next = sfrc_pkg::SEQ_OSC_WAIT;
               end
            end
            sfrc_pkg::SEQ_OSC_WAIT: begin
               if (mode_target == sfrc_pkg::SEQ_SLEEP) begin
                  seq_next = sfrc_pkg::SEQ_SLEEP;
               end else if (osc_ok) begin
                  seq_next = needs_pll(mode_target) ? sfrc_pkg::SEQ_PLL_WAIT : mode_target;
               end
            end
            sfrc_pkg::SEQ_PLL_WAIT: begin
               if (!needs_pll(mode_target) || lock_ok) begin
                  seq_next = mode_target;
               end
            end
            default: begin
               // a lock drop while running does not leave the mode
               if (mode_target != seq_reg) begin
                  seq_next = needs_pll(mode_target) ? sfrc_pkg::SEQ_PLL_WAIT : mode_target;
               end
            end
         endcase
      end
   end

   // enables are registered from the next state so they leave on flops
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         seq_reg <= sfrc_pkg::SEQ_SLEEP;
         osc_enable_out <= 1'b0;
         pll_enable_out <= 1'b0;
         tx_enable_out <= 1'b0;
         rx_enable_out <= 1'b0;
      end else begin
         seq_reg <= seq_next;
         osc_enable_out <= (seq_next != sfrc_pkg::SEQ_SLEEP);
         pll_enable_out <= needs_pll(seq_next);
         tx_enable_out <= (seq_next == sfrc_pkg::SEQ_TX);
         rx_enable_out <= (seq_next == sfrc_pkg::SEQ_RX);
      end
   end

   // -----------------------------------------------------------------------------
   // calibration triggers
   // -----------------------------------------------------------------------------
   logic coarse_done_reg;

   // coarse once after reset, fine on every pll start
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         coarse_done_reg <= 1'b0;
         coarse_cal_start_out <= 1'b0;
         fine_cal_start_out <= 1'b0;
      end else begin
         coarse_done_reg <= 1'b1;
         coarse_cal_start_out <= ~coarse_done_reg;
         fine_cal_start_out <= needs_pll(seq_next) & ~pll_enable_out;
      end
   end

   // -----------------------------------------------------------------------------
   // lock indication
   // -----------------------------------------------------------------------------
   // passed on unfiltered: wide deviation may drop it, consumers must cope
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         lock_indicate_out <= 1'b0;
         mapped_io_pin_four_out <= 1'b0;
      end else begin
         lock_indicate_out <= lock_ok & pll_enable_out;
         mapped_io_pin_four_out <= lock_ok & pll_enable_out &
            pin_map_reg[sfrc_pkg::PM_PIN4_LOCK_BIT];
      end
   end

   // -----------------------------------------------------------------------------
   // reference clock output
   // -----------------------------------------------------------------------------
   logic [DIV_W-1:0] div_cnt_reg, div_term;
   logic clk_run, div_tick;

   // terminal count 2**sel - 1, built bit by bit to avoid a wide shift
   function automatic logic [DIV_W-1:0] div_terminal(input logic [2:0] sel);
      for (int i = 0; i < DIV_W; i++) begin
         div_terminal[i] = (i < int'(sel));
      end
   endfunction

   assign div_term = div_terminal(div_sel);
   // on from reset, held low in sleep and until the oscillator is stable
   assign clk_run = osc_ok & osc_enable_out & (div_sel < sfrc_pkg::DIV_SEL_OFF);
   assign div_tick = clk_run & (div_cnt_reg == div_term);

   // a flop can only halve the reference, so select zero gives half rate
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         div_cnt_reg <= '0;
         mapped_io_pin_five_out <= 1'b0;
      end else begin
         if (!clk_run || div_tick) begin
            div_cnt_reg <= '0;
         end else begin
            div_cnt_reg <= div_cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
         end
         if (!clk_run) begin
            mapped_io_pin_five_out <= 1'b0;
         end else if (div_tick) begin
            mapped_io_pin_five_out <= ~mapped_io_pin_five_out;
         end
      end
   end

   // external reference select is a plain register bit toward the analog side
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         ext_ref_select_out <= 1'b0;
      end else begin
         ext_ref_select_out <= ext_ref_reg[sfrc_pkg::EXT_REF_BIT];
      end
   end
endmodule // sfrc_top

// file: verification/sfrc_checker.sv
// port assertions for the carrier word, clock output and start-up sequencer
// assumes it is bound into sfrc_top and sees only that module's ports
`timescale 1ns/1ps
module sfrc_checker (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic spi_nss_n_in,
   input wire logic osc_stable_in,
   input wire logic pll_lock_in,
   input wire logic spi_miso_oe_out,
   input wire logic [23:0] synth_freq_word_out,
   input wire logic synth_freq_load_out,
   input wire logic osc_enable_out,
   input wire logic pll_enable_out,
   input wire logic tx_enable_out,
   input wire logic rx_enable_out,
   input wire logic fine_cal_start_out,
   input wire logic lock_indicate_out,
   input wire logic mapped_io_pin_five_out
);
   // -------------------------------------------------------------
   // properties; inputs are synchronised, so a few cycles of slack
   // -------------------------------------------------------------
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);
   a_freq_word_held: assert property ($changed(synth_freq_word_out) |->
      synth_freq_load_out || $past(synth_freq_load_out)) else $error("word moved");
   a_ref_clock_output_quiet: assert property (!osc_stable_in [*4] |->
      !mapped_io_pin_five_out) else $error("clock out before osc");
   a_ref_clock_output_sleep: assert property (!osc_enable_out [*4] |->
      !mapped_io_pin_five_out) else $error("clock out in sleep");
   a_pll_needs_osc: assert property (pll_enable_out |-> osc_enable_out)
      else $error("pll without osc");
   a_path_needs_pll: assert property ($rose(tx_enable_out) || $rose(rx_enable_out) |->
      pll_enable_out) else $error("path before pll");
   a_one_path_only: assert property (!(tx_enable_out && rx_enable_out))
      else $error("tx and rx together");
   a_lock_shown: assert property ((pll_lock_in && pll_enable_out) [*4] |->
      lock_indicate_out) else $error("lock not shown");
   a_fine_cal_run: assert property ($rose(pll_enable_out) |-> ##[0:3] fine_cal_start_out)
      else $error("no fine cal");
   a_miso_release: assert property (spi_nss_n_in [*4] |-> !spi_miso_oe_out)
      else $error("miso driven unselected");
   c_load: cover property (synth_freq_load_out);
   c_rx: cover property ($rose(rx_enable_out));
   c_tx: cover property ($rose(tx_enable_out));
endmodule // sfrc_checker
bind sfrc_top sfrc_checker u_sfrc_checker (.sys_clk_in, .reset_in, .spi_nss_n_in,
   .osc_stable_in, .pll_lock_in, .spi_miso_oe_out, .synth_freq_word_out,
   .synth_freq_load_out, .osc_enable_out, .pll_enable_out, .tx_enable_out,
   .rx_enable_out, .fine_cal_start_out, .lock_indicate_out, .mapped_io_pin_five_out);

// file: verification/sfrc_host_model.sv
// host side model: serial port master plus oscillator and pll status
// assumes sys_clk_in at 200 MHz; sck kept at 10 MHz and idle low
`timescale 1ns/1ps
module sfrc_host_model (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic spi_miso_in,
   input wire logic osc_enable_in,
   input wire logic pll_enable_in,
   output logic spi_sck_out = 1'b0,
   output logic spi_mosi_out = 1'b0,
   output logic spi_nss_n_out = 1'b1,
   output logic osc_stable_out,
   output logic pll_lock_out
);
   logic [4:0] osc_cnt_reg = 5'h00;
   logic [4:0] pll_cnt_reg = 5'h00;
   // analog start-up: stable and lock come 20 cycles after enable
   always_ff @(posedge sys_clk_in) begin
      osc_cnt_reg <= (reset_in || !osc_enable_in) ? 5'h00 : osc_cnt_reg + {4'h0, osc_cnt_reg != 5'h14};
      pll_cnt_reg <= (reset_in || !pll_enable_in) ? 5'h00 : pll_cnt_reg + {4'h0, pll_cnt_reg != 5'h14};
   end
   assign osc_stable_out = osc_cnt_reg == 5'h14;
   assign pll_lock_out = pll_cnt_reg == 5'h14;
   // one framed single-byte access; mosi inverted once released
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
      logic [15:0] sh;
      sh = {cmd, wd};
      @(posedge sys_clk_in) spi_nss_n_out <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         spi_mosi_out <= sh[i];
         repeat (10) @(posedge sys_clk_in);
         spi_sck_out <= 1'b1;
         if (i < 8) rd[i] = spi_miso_in;
         repeat (10) @(posedge sys_clk_in);
         spi_sck_out <= 1'b0;
      end
      repeat (10) @(posedge sys_clk_in);
      spi_nss_n_out <= 1'b1;
      spi_mosi_out <= ~spi_mosi_out;
      repeat (4) @(posedge sys_clk_in);
   endtask
endmodule // sfrc_host_model

// file: verification/tb_synth_freq_refclk_control.sv
// self-checking bench for sfrc_top driven through the host model
// assumes the write flag is bit seven of the address byte
`timescale 1ns/1ps
module tb_synth_freq_refclk_control;
   logic clk = 1'b0, rst = 1'b1, miso, oe, load, osc_en, pll_en, tx, rx, cc, fc, lk, p5, ext;
   logic sck, mosi, nss, ostb, plk, p4, p5_q = 1'b0;
   int ccs = 0, fcs = 0;
   logic [23:0] word;
   logic [7:0] rv;
   int error_cnt = 0, total_checks = 0, tog = 0, loads = 0, t0;
   always #2.5 clk = ~clk;
   sfrc_top u_sfrc_top (.sys_clk_in(clk), .reset_in(rst), .spi_sck_in(sck),
      .spi_mosi_in(mosi), .spi_nss_n_in(nss), .osc_stable_in(ostb), .pll_lock_in(plk),
      .spi_miso_out(miso), .spi_miso_oe_out(oe), .synth_freq_word_out(word),
      .synth_freq_load_out(load), .osc_enable_out(osc_en), .pll_enable_out(pll_en),
      .tx_enable_out(tx), .rx_enable_out(rx), .coarse_cal_start_out(cc),
      .fine_cal_start_out(fc), .lock_indicate_out(lk), .mapped_io_pin_four_out(p4),
      .mapped_io_pin_five_out(p5), .ext_ref_select_out(ext));
   sfrc_host_model u_sfrc_host_model (.sys_clk_in(clk), .reset_in(rst),
      .spi_miso_in(oe ? miso : 1'bz), .osc_enable_in(osc_en), .pll_enable_in(pll_en),
      .spi_sck_out(sck), .spi_mosi_out(mosi), .spi_nss_n_out(nss),
      .osc_stable_out(ostb), .pll_lock_out(plk));
   // ---------------------------------------------------------------
   // helpers: edge and pulse counters, access tasks, compare, verdict
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      tog <= tog + (p5 !== p5_q);
      p5_q <= p5;
      loads <= loads + (load === 1'b1);
      ccs <= ccs + (cc === 1'b1);
      fcs <= fcs + (fc === 1'b1);
   end
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      u_sfrc_host_model.xfer({1'b1, a}, d, rv);
      repeat (8) @(posedge clk);
   endtask
   task automatic rd(input logic [6:0] a);
      u_sfrc_host_model.xfer({1'b0, a}, 8'h00, rv);
   endtask
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // hang guard, far beyond the roughly 5200 cycles the tests take
   initial begin
      repeat (40000) @(posedge clk);
      error_cnt++;
      conclude();
   end
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(sfrc_pkg::ADDR_FREQ_HIGH); check(rv, sfrc_pkg::RST_FREQ_BYTE);
      rd(sfrc_pkg::ADDR_PIN_MAP_SECOND); check(rv, sfrc_pkg::RST_PIN_MAP_SECOND);
      rd(sfrc_pkg::ADDR_EXT_REF_SEL); check(rv, sfrc_pkg::RST_EXT_REF_SEL);
      check(tog != 0, 1'b1);
      rd(sfrc_pkg::ADDR_SEQ_STATUS); check(rv, 8'h01);
      wr(sfrc_pkg::ADDR_FREQ_HIGH, 8'h6c);
      wr(sfrc_pkg::ADDR_FREQ_MID, 8'h80);
      check(word, {3{sfrc_pkg::RST_FREQ_BYTE}});
      check(loads, 0);
      wr(sfrc_pkg::ADDR_FREQ_LOW, 8'h40);
      check(word, 24'h6c8040);
      check(loads != 0, 1'b1);
      rd(sfrc_pkg::ADDR_FREQ_MID); check(rv, 8'h80);
      wr(sfrc_pkg::ADDR_EXT_REF_SEL, 8'h10);
      check(ext, 1'b1);
      wr(sfrc_pkg::ADDR_PIN_MAP_SECOND, {5'h00, sfrc_pkg::DIV_SEL_OFF});
      t0 = tog;
      repeat (200) @(posedge clk);
      check(tog - t0, 0);
      wr(sfrc_pkg::ADDR_OP_MODE, {3'h0, sfrc_pkg::MODE_RX, 2'h0});
      for (int k = 0; k < 600 && rx !== 1'b1; k++) @(posedge clk);
      check({rx, pll_en, lk}, 3'h7);
      wr(sfrc_pkg::ADDR_OP_MODE, {3'h0, sfrc_pkg::MODE_TX, 2'h0});
      for (int k = 0; k < 600 && tx !== 1'b1; k++) @(posedge clk);
      check({tx, rx}, 2'h2);
      wr(sfrc_pkg::ADDR_PIN_MAP_SECOND, 8'h40);
      check(p4, 1'b1);
      wr(sfrc_pkg::ADDR_OP_MODE, {3'h0, sfrc_pkg::MODE_SLEEP, 2'h0});
      t0 = tog;
      repeat (200) @(posedge clk);
      check({osc_en, tog != t0}, 2'h0);
      check(ccs, 1);
      check(fcs, 1);
      conclude();
   end
endmodule // tb_synth_freq_refclk_control
